// ===== adc_seq_consts.svh
// Constants of the octal converter serial sequencer
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// ==========================================================================
// Frame counter (counts rising serial clock edges, wraps every conversion)
`define ADC_CNT_W 4
`define ADC_CNT_ZERO 4'h0
`define ADC_CNT_ONE 4'h1
`define ADC_TRACK_LAST 4'h2
`define ADC_HOLD_CNT 4'h3
`define ADC_ZERO_EDGES 4'h4
`define ADC_CTL_LAST 4'h7
`define ADC_CTL_BITS 4'h8
`define ADC_CONV_LAST 4'hF

// ==========================================================================
// Data widths and reset values
`define ADC_RES_W 12
`define ADC_CTL_W 8
`define ADC_CHAN_W 3
`define ADC_IGN_HI_W 2
`define ADC_IGN_LO_W 3
`define ADC_STAT_W 4
`define ADC_CHAN_RESET 3'h0
`define ADC_WORD_RESET 12'h000
`define ADC_STAT_RESET 4'h1

`endif

// ===== adc_seq_pkg.sv
// Types shared by the octal converter serial sequencer
`include "adc_seq_consts.svh"

package adc_seq_pkg;

   // ========================================================================
   // Control byte as shifted in, most significant bit first
   typedef struct packed {
      logic [`ADC_IGN_HI_W-1:0] ignored_hi;
      logic [`ADC_CHAN_W-1:0] channel_code;
      logic [`ADC_IGN_LO_W-1:0] ignored_lo;
   } ctl_s;

   // ========================================================================
   // Link-domain levels carried to the core clock
   typedef struct packed {
      logic ctl_ready;
      logic pwr_down;
      logic track;
      logic sel_n;
   } link_stat_s;

   typedef logic [`ADC_RES_W-1:0] result_t;

endpackage

// ===== adc_sync2.sv
// Two-stage level synchroniser into the core clock domain
`timescale 1ns/100ps
`include "adc_seq_consts.svh"

module adc_sync2 #(
   parameter int W = `ADC_STAT_W,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ========================================================================
   // First stage feeds only the second stage
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else
      begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;

endmodule

// ===== octal_adc_serial_sequencer.sv
// Serial port, frame sequencing and channel control of an eight-channel converter
`timescale 1ns/100ps
`include "adc_seq_consts.svh"

// Summary of operation
// - Track for the first three serial clock cycles of every conversion.
// - Hold and convert for the next thirteen cycles while shifting data out.
// - Result is straight binary; one step is reference over 4096.
// - Falling edges 1-4 give zeros, edges 5-16 the 12-bit result MSB first.
// - Serial output is driven only while select is low.
// - Serial clock activity is ignored while select is high.
// - Back to track after rising edge 16N, to hold on falling edge 16N+4.
// - Conversions of 16 cycles repeat back to back while select stays low.
// - Powered while select low; powered down from falling edge 16 to next 1.
// - Select falling with clock low counts as the first falling edge.
// - Command input sampled on rising edges; first eight load the control byte.
// - Control bits 7, 6, 2, 1 and 0 have no effect.
// - Bits 5 to 3 pick the analog input for the next conversion.
// - First conversion after power-up uses channel zero, no dummy cycle.
module octal_adc_serial_sequencer (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_o,
   input wire logic [`ADC_RES_W-1:0] conv_word_i,
   input wire logic conv_valid_i,
   output logic [`ADC_CHAN_W-1:0] channel_o,
   output logic track_o,
   output logic power_up_o
);

   // ========================================================================
   // Link-domain state
   logic [`ADC_CNT_W-1:0] cnt_q;
   logic [`ADC_CTL_W-1:0] shift_q;
   adc_seq_pkg::ctl_s ctl_byte_q;
   logic ctl_ready_q;
   logic wtog_s1_q;
   logic wtog_s2_q;
   logic wtog_s3_q;
   adc_seq_pkg::result_t held_q;
   adc_seq_pkg::result_t shift_word_q;
   logic track_q;
   logic pd_q;
   logic dout_q;

   // ========================================================================
   // Core-domain state
   adc_seq_pkg::link_stat_s stat_s;
   logic ctl_seen_q;
   logic [`ADC_CHAN_W-1:0] channel_q;
   adc_seq_pkg::result_t word_q;
   logic word_tog_q;
   logic track_out_q;
   logic power_q;

   // Picks the result bit for a given count; count 4 gives the MSB
   function automatic logic result_bit(input adc_seq_pkg::result_t word,
                                       input logic [`ADC_CNT_W-1:0] cnt);
      logic [`ADC_CNT_W-1:0] idx;
      idx = `ADC_CONV_LAST - cnt;
      return word[idx];
   endfunction

   // ========================================================================
   // Link side: rising-edge logic

   // Rising edge counter; select high holds it clear so stray clocks do nothing
   always_ff @(posedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
         cnt_q <= `ADC_CNT_ZERO;
      else
         cnt_q <= cnt_q + `ADC_CNT_ONE; // Wraps every 16 rises
   end

   // Command input shifts in during the first eight rises of each conversion
   always_ff @(posedge sclk_i)
   begin
      if (cnt_q < `ADC_CTL_BITS)
         shift_q <= {shift_q[`ADC_CTL_W-2:0], din_i}; // MSB first
   end

   // Whole byte lands on the eighth rise and stays until the next conversion
   always_ff @(posedge sclk_i)
   begin
      if (cnt_q == `ADC_CTL_LAST)
         ctl_byte_q <= {shift_q[`ADC_CTL_W-2:0], din_i};
   end

   // Byte-ready level lasts eight rises, long enough for the core to see it
   always_ff @(posedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
         ctl_ready_q <= 1'b0;
      else if (cnt_q == `ADC_CTL_LAST)
         ctl_ready_q <= 1'b1;
      else if (cnt_q == `ADC_CONV_LAST)
         ctl_ready_q <= 1'b0;
   end

   // Result toggle synchroniser; cleared with select so each frame re-syncs
   always_ff @(posedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
      begin
         wtog_s1_q <= 1'b0;
         wtog_s2_q <= 1'b0;
         wtog_s3_q <= 1'b0;
      end
      else
      begin
         wtog_s1_q <= word_tog_q;
         wtog_s2_q <= wtog_s1_q;
         wtog_s3_q <= wtog_s2_q;
      end
   end

   // Word is copied after its toggle has settled, and again on rise 3 of every
   // conversion: the chain is cleared with select, so a toggle that moved while
   // select was high would otherwise never be seen. A word published within
   // two link periods of rise 3 may still be torn.
   always_ff @(posedge sclk_i)
   begin
      if (wtog_s2_q != wtog_s3_q || cnt_q == `ADC_TRACK_LAST)
         held_q <= word_q;
   end

   // Result freezes on rise 4, just before the first data edge
   always_ff @(posedge sclk_i)
   begin
      if (cnt_q == `ADC_HOLD_CNT)
         shift_word_q <= held_q; // Passed through unchanged, straight binary
   end

   // ========================================================================
   // Link side: falling-edge logic
   // Falling edge number is always count plus one; with select falling while
   // the clock is low, the select fall itself was edge 1 via the reset values.

   // Track on edges 1-3 of each conversion, hold from edge 4
   always_ff @(negedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
         track_q <= 1'b1; // Select fall enters track at once
      else
         track_q <= (cnt_q <= `ADC_TRACK_LAST);
   end

   // Power-down gap between edge 16 and the next edge 1
   always_ff @(negedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
         pd_q <= 1'b0;
      else
         pd_q <= (cnt_q == `ADC_CONV_LAST);
   end

   // Serial output: four leading zeros then twelve result bits
   always_ff @(negedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
         dout_q <= 1'b0;
      else if (cnt_q < `ADC_ZERO_EDGES)
         dout_q <= 1'b0;
      else
         dout_q <= result_bit(shift_word_q, cnt_q);
   end

   assign dout_o = dout_q;
   // Enable must follow select without a clock edge, so it is not registered
   assign dout_oe_o = ~cs_n_i;

   // ========================================================================
   // Crossing of link levels into the core clock
   adc_sync2 #(
      .W(`ADC_STAT_W),
      .RST_VAL(`ADC_STAT_RESET)
   ) u_stat_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .d_i({ctl_ready_q, pd_q, track_q, cs_n_i}),
      .q_o(stat_s)
   );

   // ========================================================================
   // Core side: channel selection

   // Edge memory of the byte-ready level
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         ctl_seen_q <= 1'b0;
      else
         ctl_seen_q <= stat_s.ctl_ready;
   end

   // New code takes effect at the next track phase; the current sample is held
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         channel_q <= `ADC_CHAN_RESET;
      else if (stat_s.ctl_ready && !ctl_seen_q)
         channel_q <= ctl_byte_q.channel_code; // Other fields unused
   end

   assign channel_o = channel_q;

   // ========================================================================
   // Core side: converter status toward the analog section

   // Track and power levels, both forced off while select is high
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         track_out_q <= 1'b0;
         power_q <= 1'b0;
      end
      else
      begin
         track_out_q <= stat_s.track && !stat_s.sel_n;
         power_q <= !stat_s.sel_n && !stat_s.pwr_down;
      end
   end

   assign track_o = track_out_q;
   assign power_up_o = power_q;

   // ========================================================================
   // Core side: result publication
   // Toggle starts at one so the first frame after reset loads a defined word.
   // Words arriving faster than the link can re-sync them may be torn.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         word_q <= `ADC_WORD_RESET;
         word_tog_q <= 1'b1;
      end
      else if (conv_valid_i)
      begin
         word_q <= conv_word_i;
         word_tog_q <= ~word_tog_q;
      end
   end

   // ========================================================================
   // Checks on the link side

   a_track_phase: assert property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (cnt_q < `ADC_HOLD_CNT) |-> track_q)
      else $error("Not tracking during the first three cycles");

   a_hold_phase: assert property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (cnt_q == `ADC_HOLD_CNT) |-> !track_q ##1 !track_q [*8])
      else $error("Hold phase broken before conversion end");

   a_lead_zeros: assert property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (cnt_q == `ADC_CNT_ONE) |-> !dout_q ##1 !dout_q ##1 !dout_q)
      else $error("Leading zero missing");

   a_msb_order: assert property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (cnt_q == `ADC_HOLD_CNT) ##1 1'b1 |-> dout_q == $past(held_q[`ADC_RES_W-1], 1))
      else $error("First data bit is not the result MSB");

   a_lsb_last: assert property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (cnt_q == `ADC_CONV_LAST) |-> dout_q == $past(held_q[0], `ADC_RES_W))
      else $error("Last data bit is not the result LSB");

   a_count_wrap: assert property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (cnt_q == `ADC_CONV_LAST) |=> (cnt_q == `ADC_CNT_ZERO) ##3 !track_q)
      else $error("Conversion did not restart after 16 rises");

   a_retrack: assert property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (cnt_q == `ADC_CONV_LAST) ##1 1'b1 |-> track_q && !pd_q)
      else $error("No return to track after rise 16N");

   a_power_gap: assert property (
      @(posedge sclk_i) disable iff (cs_n_i)
      pd_q |-> (cnt_q == `ADC_CONV_LAST))
      else $error("Power-down outside the inter-conversion gap");

   a_ctl_byte: assert property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (cnt_q == `ADC_CNT_ZERO) ##7 1'b1 |=>
         ctl_byte_q == {$past(din_i, 8), $past(din_i, 7), $past(din_i, 6),
                        $past(din_i, 5), $past(din_i, 4), $past(din_i, 3),
                        $past(din_i, 2), $past(din_i, 1)})
      else $error("Control byte not taken MSB first from rises 1 to 8");

   // ========================================================================
   // Checks on the core side

   a_chan_reset: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $past(!rst_n_i) |-> (channel_q == `ADC_CHAN_RESET))
      else $error("Channel not zero after reset");

   a_chan_update: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(stat_s.ctl_ready) |=> channel_q == $past(ctl_byte_q.channel_code))
      else $error("Channel code not applied");

   a_chan_hold: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !(stat_s.ctl_ready && !ctl_seen_q) |=> $stable(channel_q))
      else $error("Channel changed without a new control byte");

   a_power_off: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      stat_s.sel_n |=> !power_q && !track_out_q)
      else $error("Powered while select is high");

   // ========================================================================
   // Scenario coverage

   c_two_conv: cover property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (cnt_q == `ADC_CONV_LAST) ##1 (cnt_q == `ADC_CNT_ZERO) ##8 ctl_ready_q);

   c_chan_change: cover property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $changed(channel_q));

   c_new_word: cover property (
      @(posedge sclk_i) disable iff (cs_n_i)
      (wtog_s2_q != wtog_s3_q) ##[1:16] (cnt_q == `ADC_HOLD_CNT));

   c_pd_gap: cover property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !stat_s.sel_n && stat_s.pwr_down);

endmodule

// ===== serial_host_model.sv
// Serial host model that frames conversions and collects the results
`timescale 1ns/100ps

module serial_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o,
   input wire logic sdo_i
);
   // =======================================================================
   // Command bytes to send and words collected, one entry per conversion
   logic [7:0] ctl_q [8];
   logic [15:0] rx_q [8];

   // Idle levels; the clock rests high between frames unless idle_clocks runs it
   initial
   begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o = 1'b0;
   end

   // Full clock periods with select high; the device must not count them
   task automatic idle_clocks(input int n);
      for (int i = 0; i < 2 * n; i++)
      begin
         #6;
         sclk_o = ~sclk_o;
      end
   endtask

   // One frame of n conversions; idle_low chooses select falling with clock low
   task automatic run_frame(input int n, input logic idle_low);
      sclk_o = ~idle_low;
      #3.3;
      cs_n_o = 1'b0;
      for (int i = 0; i < 16 * n; i++)
      begin
         if (i > 0 || !idle_low)
         begin
            #6;
            sclk_o = 1'b0;
         end
         // Fresh byte each conversion, MSB first; filler toggles
         din_o = (i % 16 < 8) ? ctl_q[i / 16][7 - i % 16] : ~din_o;
         #6;
         sclk_o = 1'b1;
         rx_q[i / 16] = {rx_q[i / 16][14:0], sdo_i};
      end
      #6;
      cs_n_o = 1'b1;
      din_o = ~din_o; // Released line must not look like held data
      #6;
   endtask
endmodule

// ===== tb_top.sv
// Testbench for the octal converter serial sequencer
`timescale 1ns/100ps
`include "adc_seq_consts.svh"

module tb_top;
   logic core_clk;
   logic rst_n;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;
   logic dout_oe;
   logic sdo;
   logic sdo_last = 1'b0;
   logic [`ADC_RES_W-1:0] conv_word;
   logic conv_valid;
   logic [`ADC_CHAN_W-1:0] channel;
   logic track;
   logic power_up;
   int miscompares;
   int comparisons;

   // =======================================================================
   // Clock, line model and instances
   always #10 core_clk = ~core_clk;

   // Undriven output line shows the inverse of its last driven level
   always @(dout, dout_oe)
   begin
      if (dout_oe)
         sdo_last = dout;
   end
   assign sdo = dout_oe ? dout : ~sdo_last;

   octal_adc_serial_sequencer i_dut (
      .core_clk_i(core_clk),
      .rst_n_i(rst_n),
      .sclk_i(sclk),
      .cs_n_i(cs_n),
      .din_i(din),
      .dout_o(dout),
      .dout_oe_o(dout_oe),
      .conv_word_i(conv_word),
      .conv_valid_i(conv_valid),
      .channel_o(channel),
      .track_o(track),
      .power_up_o(power_up)
   );

   serial_host_model i_host (
      .sclk_o(sclk),
      .cs_n_o(cs_n),
      .din_o(din),
      .sdo_i(sdo)
   );

   // =======================================================================
   // Shared tasks
   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Publish a converter word one core cycle long, then let it settle
   task automatic publish(input logic [`ADC_RES_W-1:0] w);
      @(negedge core_clk);
      conv_word = w;
      conv_valid = 1'b1;
      @(negedge core_clk);
      conv_valid = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask

   // =======================================================================
   // Scenarios
   task automatic test_reset();
      compare({13'h0, channel}, 16'h0000);
      compare({15'h0, power_up}, 16'h0000);
      compare({15'h0, dout_oe}, 16'h0000);
   endtask

   // First conversion, with mid-frame checks of enable, power and phase
   task automatic test_single();
      publish(12'hA5C);
      i_host.ctl_q[0] = 8'h28;
      fork
         i_host.run_frame(1, 1'b0);
         begin
            #100;
            compare({15'h0, dout_oe}, 16'h0001);
            compare({15'h0, power_up}, 16'h0001);
            compare({15'h0, track}, 16'h0000);
            compare({13'h0, channel}, 16'h0000);
         end
      join
      compare(i_host.rx_q[0], 16'h0A5C);
      repeat (6) @(negedge core_clk);
      compare({13'h0, channel}, 16'h0005);
      compare({15'h0, power_up}, 16'h0000);
      compare({15'h0, dout_oe}, 16'h0000);
   endtask

   // Every channel code, ignored bits opposite, both select-fall cases
   task automatic test_channels();
      logic [2:0] c;
      publish(12'h801);
      for (int i = 0; i < 8; i++)
      begin
         c = 3'(i);
         i_host.ctl_q[0] = {2'b10, c, 3'b011};
         i_host.run_frame(1, c[0]);
         repeat (6) @(negedge core_clk);
         compare({13'h0, channel}, {13'h0, c});
         compare(i_host.rx_q[0], 16'h0801);
      end
   endtask

   // Stray clocks with select high, then four conversions in one frame
   task automatic test_continuous();
      publish(12'h7E9);
      i_host.idle_clocks(5);
      compare({15'h0, power_up}, 16'h0000);
      i_host.ctl_q[0] = 8'hCF;
      i_host.ctl_q[1] = 8'hD7;
      i_host.ctl_q[2] = 8'hDF;
      i_host.ctl_q[3] = 8'hF7;
      i_host.run_frame(4, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         compare(i_host.rx_q[k], 16'h07E9);
      end
      repeat (6) @(negedge core_clk);
      compare({13'h0, channel}, 16'h0006);
   endtask

   // =======================================================================
   // Main sequence and hang guard
   initial
   begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      conv_word = 12'h000;
      conv_valid = 1'b0;
      miscompares = 0;
      comparisons = 0;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      test_reset();
      test_single();
      test_channels();
      test_continuous();
      stop_test();
   end

   // A hang counts as a mismatch and ends the run
   initial
   begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      stop_test();
   end
endmodule
